/* File: sim/smsf_monitor.sv */
// Port checker for smsf_top: APB timing, select pattern, serial clock, faults.
// Assumes APB master on clk_sys; bound to every smsf_top instance.
module smsf_monitor (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire sckOut,
    input wire sckOutEn,
    input wire slaveSelectN,
    input wire [7:0] targetSelectOutputs,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctrl_q;
    logic [7:0] sel_q;
    logic [10:0] gap_q;
    logic [4:0] edge_q;
    logic sck_q;
    wire apbDone = psel && penable && pready;
    wire sckChg = sckOut != sck_q;
    wire [4:0] edgeNow = edge_q + {4'h0, sckChg};
    wire [10:0] half = 11'h4 << ctrl_q[6:4];
    wire selIdle = targetSelectOutputs == 8'hff;
    wire ieNow = ctrl_q[7];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Shadows of control and select, gap and edge counters
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= 8'h00;
            sel_q <= 8'hff;
            gap_q <= 11'h0;
            edge_q <= 5'h0;
            sck_q <= 1'b0;
        end else begin
            sck_q <= sckOut;
            gap_q <= sckChg ? 11'h1 : gap_q + 11'h1;
            edge_q <= selIdle ? 5'h0 : edgeNow;
            if (apbDone && pwrite && paddr == 8'h00)
                ctrl_q <= pwdata[7:0];
            if (apbDone && pwrite && paddr == 8'h0c)
                sel_q <= pwdata[7:0];
        end
    end
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (apbDone |-> pslverr == (paddr > 8'h10))
        else $error("pslverr wrong for address");
    a_sel_pattern: assert property (!selIdle |-> targetSelectOutputs == sel_q)
        else $error("target selects differ from pattern");
    a_sel_master: assert property (!selIdle |-> sckOutEn)
        else $error("targets selected without master drive");
    a_sck_half: assert property (sckChg && !selIdle && edge_q != 0 |-> gap_q == half)
        else $error("serial clock half period wrong");
    a_edge_count: assert property (selIdle && !$past(selIdle) |-> edgeNow == 5'd16)
        else $error("transfer not sixteen clock edges");
    a_modf_off: assert property (!slaveSelectN [*8] |-> !sckOutEn)
        else $error("drivers still on under mode fault");
    a_irq_enable: assert property (irq |-> $past(ieNow))
        else $error("irq without enable");
    cover property (selIdle && !$past(selIdle));
    cover property (irq);
    cover property (!slaveSelectN && !sckOutEn);
endmodule

bind smsf_top smsf_monitor i_mon (
    .clk_sys(clk_sys),
    .rst(rst),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .sckOut(sckOut),
    .sckOutEn(sckOutEn),
    .slaveSelectN(slaveSelectN),
    .targetSelectOutputs(targetSelectOutputs),
    .irq(irq)
);

/* File: sim/smsf_slave_model.sv */
// Behavioural SPI target on the far side of the master pins.
// Assumes phase and polarity given by the bench, select active low.
module smsf_slave_model (
    input wire sckIn,
    input wire mosi,
    input wire csN,
    input wire clock_polarity_bit,
    input wire clock_phase_bit,
    input wire [7:0] txByte,
    output logic miso,
    output logic [7:0] rxByte,
    output logic doneTgl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh = 8'h00;
    logic [7:0] rx = 8'h00;
    logic lastBit = 1'b0;
    logic first = 1'b0;
    int n = 0;
    initial begin
        rxByte = 8'h00;
        doneTgl = 1'b0;
    end
    // Released line shows the inverse of its last bit
    assign miso = csN ? ~lastBit : sh[7];
    always @(negedge csN) begin
        sh = txByte;
        n = 0;
        first = 1'b1;
    end
    always @(posedge csN) lastBit = sh[7];
    // Sample on one edge, shift on the other
    always @(sckIn) begin
        if (!csN) begin
            if ((sckIn != clock_polarity_bit) != clock_phase_bit) begin
                rx = {rx[6:0], mosi};
                n++;
                if (n == 8) begin
                    rxByte = rx;
                    doneTgl = ~doneTgl;
                end
            end else if (clock_phase_bit && first)
                first = 1'b0;
            else
                sh = {sh[6:0], 1'b0};
        end
    end
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for smsf_top: APB tasks, SPI target model, queues.
// Assumes smsf_top and the bound checker are compiled beforehand.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic slaveSelectN = 1'b1;
    logic modeCpol = 1'b0;
    logic modeCpha = 1'b0;
    logic [7:0] slvTx = 8'h00;
    logic [7:0] tx;
    logic [7:0] sb;
    logic [31:0] seed = 32'h8c23;
    wire [31:0] prdata;
    wire [7:0] tsel;
    wire [7:0] slvRx;
    wire pready, pslverr, sckOut, masterDataOut, irq, txReady, rxReady, mi, doneTgl;
    int badCount = 0;
    int cmpCount = 0;
    logic [32:0] rdQ[$];
    logic [31:0] mkQ[$];
    logic [7:0] spiQ[$];
    initial forever #2 clk_sys = ~clk_sys;
    smsf_top i_dut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scki(1'b0), .mi(mi), .si(1'b0),
        .slaveSelectN(slaveSelectN), .sckOut(sckOut), .sckOutEn(),
        .masterDataOut(masterDataOut), .masterDataOutEn(), .slaveDataOut(),
        .slaveDataOutEn(), .targetSelectOutputs(tsel), .irq(irq),
        .txReady(txReady), .rxReady(rxReady));
    smsf_slave_model i_slv (.sckIn(sckOut), .mosi(masterDataOut), .csN(tsel[0]),
        .clock_polarity_bit(modeCpol), .clock_phase_bit(modeCpha), .txByte(slvTx), .miso(mi),
        .rxByte(slvRx), .doneTgl(doneTgl));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmpCount++;
        if (g !== e) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task test_done;
        $display("Compares %0d, mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] m = 32'hffffffff);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) begin
            rdQ.push_back({a > 8'h10, d});
            mkQ.push_back(m);
        end
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitDone();
        while (tsel === 8'hff) @(posedge clk_sys);
        while (tsel !== 8'hff) @(posedge clk_sys);
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic xfer(logic [7:0] t, logic [7:0] s);
        slvTx <= s;
        spiQ.push_back(t);
        apb(1'b1, 8'h08, {24'h0, t});
        waitDone();
    endtask
    // Read results and received serial bytes
    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite) begin
            chk("prdata", rdQ[0][31:0] & mkQ[0], prdata & mkQ[0]);
            chk("pslverr", {31'h0, rdQ[0][32]}, {31'h0, pslverr});
            void'(rdQ.pop_front());
            void'(mkQ.pop_front());
        end
    end
    always @(doneTgl) if (!rst) chk("spi rx", spiQ.pop_front(), slvRx);
    initial begin
        #200000;
        badCount++;
        test_done;
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        apb(1'b0, 8'h0c, 32'hff);
        apb(1'b0, 8'h10, 32'h100);
        apb(1'b0, 8'h20, 32'h0);
        apb(1'b1, 8'h0c, 32'hfe);
        for (int i = 0; i < 5; i++) begin
            modeCpha <= i[1];
            modeCpol <= i[0];
            apb(1'b1, 8'h00, {25'h0, (i == 4) ? 3'h7 : i[2:0], i[1], i[0], 2'b11});
            tx = rnd();
            sb = rnd();
            xfer(tx, sb);
            apb(1'b0, 8'h04, 32'h1, 32'h1);
            apb(1'b0, 8'h08, {24'h0, sb});
            apb(1'b0, 8'h04, 32'h0, 32'h1);
        end
        xfer(8'h3c, 8'h5a);
        xfer(8'hc3, 8'ha5);
        apb(1'b0, 8'h04, 32'h9, 32'h9);
        apb(1'b0, 8'h08, 32'h5a);
        slvTx <= 8'h77;
        spiQ.push_back(8'h11);
        apb(1'b1, 8'h08, 32'h11);
        apb(1'b1, 8'h08, 32'h22);
        waitDone();
        apb(1'b0, 8'h04, 32'h3, 32'hf);
        apb(1'b0, 8'h08, 32'h77);
        slaveSelectN <= 1'b0;
        repeat (10) @(posedge clk_sys);
        apb(1'b0, 8'h04, 32'h4, 32'h4);
        apb(1'b0, 8'h00, 32'h0, 32'h2);
        slaveSelectN <= 1'b1;
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h04, 32'h0, 32'h4);
        modeCpha <= 1'b0;
        modeCpol <= 1'b0;
        slvTx <= 8'h96;
        apb(1'b1, 8'h10, 32'h101);
        apb(1'b1, 8'h00, 32'h93);
        for (int i = 0; i < 17; i++) begin
            tx = rnd();
            spiQ.push_back(tx);
            apb(1'b1, 8'h08, {24'h0, tx});
        end
        repeat (2) @(posedge clk_sys);
        chk("txReady", 32'h0, {31'h0, txReady});
        apb(1'b1, 8'h08, 32'hee);
        while (txReady !== 1'b1) @(posedge clk_sys);
        spiQ.push_back(8'h5b);
        apb(1'b1, 8'h08, 32'h5b);
        while (spiQ.size() != 0) @(posedge clk_sys);
        repeat (8) @(posedge clk_sys);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b0, 8'h04, 32'h19, 32'h19);
        for (int i = 0; i < 16; i++) apb(1'b0, 8'h08, 32'h96);
        apb(1'b0, 8'h08, 32'h0);
        repeat (4) @(posedge clk_sys);
        chk("irq", 32'h0, {31'h0, irq});
        test_done;
    end
endmodule

/* File: src/smsf_defs.vh */
// Constants for the SPI master/slave block with FIFOs.
// Assumes a 250 MHz clk_sys and an APB master with 32-bit data.
// Overview of operation
// - Transmit is single buffered: no new byte enters the shifter mid-transfer.
// - A finished receive byte moves to a separate receive buffer at once.
// - Overrun only when a new byte completes before the old one was read.
// - Each transfer swaps 8 bits out and 8 bits in, a 16-bit ring.
// - Receive FIFO of 16 or 64 entries; trigger level with enable requests interrupt.
// - Full receive FIFO stores nothing more; further bytes set overrun.
// - Master starts shifting as soon as a byte sits in the transmit FIFO.
// - Slave starts shifting only after the proper leading clock edge.
// - Host writes are blocked while the transmit FIFO holds its capacity.
// - Writes are accepted again once a byte moved to the shifter.
// - Control register always accessible: role, polarity, phase and rate.
// - Status is read only; hardware sets flags, a software sequence clears.
// - Master start drives the select pattern onto eight target selects.
// - Polarity only chooses the idle level of the serial clock.
// - Phase chooses one of two formats; four combinations in total.
// - Both ends use the same phase and polarity, changeable between transfers.
// - Controller makes the interrupt request and detects transfer errors.
// - With the FIFO off, writing data while a transfer runs or a byte waits raises write collision.
// - Second master detected: mode fault flagged, serial drivers disabled.
// - Master clock rate: eight choices from clk/8 to clk/1024.
`ifndef SMSF_DEFS_VH
`define SMSF_DEFS_VH

`define SMSF_OFF_CTRL 8'h00
`define SMSF_OFF_STAT 8'h04
`define SMSF_OFF_DATA 8'h08
`define SMSF_OFF_SEL 8'h0c
`define SMSF_OFF_FCTL 8'h10

`define SMSF_CTRL_EN 0
`define SMSF_CTRL_MSTR 1
`define SMSF_CTRL_CLOCK_POLARITY_BIT 2
`define SMSF_CTRL_CLOCK_PHASE_BIT 3
`define SMSF_CTRL_RATE_LO 4
`define SMSF_CTRL_RATE_HI 6
`define SMSF_CTRL_IE 7

`define SMSF_ST_TCF 0
`define SMSF_ST_WCOL 1
`define SMSF_ST_MODF 2
`define SMSF_ST_OVR 3

`define SMSF_FC_EN 0
`define SMSF_FC_RXCLR 1
`define SMSF_FC_TXCLR 2
`define SMSF_FC_BIG 5
`define SMSF_FC_TRIG_LO 8
`define SMSF_FC_TRIG_HI 14

`define SMSF_CTRL_RST 8'h00
`define SMSF_FCTL_RST 15'h0100
`define SMSF_SEL_RST 8'hff
`define SMSF_SEL_IDLE 8'hff

`define SMSF_CAP_SMALL 7'h10
`define SMSF_CAP_BIG 7'h40
`define SMSF_CAP_ONE 7'h01
`define SMSF_HALF_MIN 10'h004
`define SMSF_LAST_EDGE 4'hf

`endif

/* File: src/smsf_fifo.v */
// Byte FIFO of fixed depth with a run-time capacity limit.
// Assumes one clock; pushes and pops come from logic on that clock.
module smsf_fifo (
    input wire clk_sys,
    input wire rst,
    input wire clr,
    input wire [6:0] limit,
    input wire wrValid,
    output wire wrReady,
    input wire [7:0] wrData,
    output wire rdValid,
    input wire rdReady,
    output wire [7:0] rdData,
    output wire [6:0] count
);
    localparam DEPTH = 64;

    reg [7:0] memQ [0:DEPTH-1];
    reg [5:0] wrPtrQ;
    reg [5:0] rdPtrQ;
    reg [6:0] countQ;
    wire doWr;
    wire doRd;

    assign wrReady = (countQ < limit);
    assign rdValid = (countQ != 7'h00);
    assign rdData = memQ[rdPtrQ];
    assign count = countQ;
    assign doWr = wrValid & wrReady;
    assign doRd = rdReady & rdValid;

    always @(posedge clk_sys) begin
        if (doWr) begin
            memQ[wrPtrQ] <= wrData;
        end
    end

    always @(posedge clk_sys) begin
        if (rst | clr) begin
            wrPtrQ <= 6'h00;
            rdPtrQ <= 6'h00;
            countQ <= 7'h00;
        end else begin
            if (doWr) begin
                wrPtrQ <= wrPtrQ + 6'h01;
            end
            if (doRd) begin
                rdPtrQ <= rdPtrQ + 6'h01;
            end
            if (doWr & ~doRd) begin
                countQ <= countQ + 7'h01;
            end else if (doRd & ~doWr) begin
                countQ <= countQ - 7'h01;
            end
        end
    end
endmodule

/* File: src/smsf_top.v */
// SPI master/slave engine with transmit and receive FIFOs, APB registers.
// Assumes APB master on clk_sys; serial pins are asynchronous to clk_sys.
//
// Chosen here: the register addresses and the APB slave port.
`include "smsf_defs.vh"
module smsf_top (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire scki,
    input wire mi,
    input wire si,
    input wire slaveSelectN,
    output wire sckOut,
    output wire sckOutEn,
    output wire masterDataOut,
    output wire masterDataOutEn,
    output wire slaveDataOut,
    output wire slaveDataOutEn,
    output wire [7:0] targetSelectOutputs,
    output wire irq,
    output wire txReady,
    output wire rxReady
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_RUN = 3'b100;

    // Pin synchronisers: {ss, si, mi, sck}
    reg [3:0] sync1Q;
    reg [3:0] sync2Q;
    reg sckPrevQ;

    reg [7:0] serialControlRegQ;
    reg [14:0] fifoControlRegQ;
    reg [7:0] selectPatternRegQ;
    reg tcfQ;
    reg wcolQ;
    reg modfQ;
    reg ovrQ;
    reg [3:0] seenQ;

    reg readyQ;
    reg slverrQ;
    reg [31:0] prdataQ;
    reg rxTakeQ;
    reg [31:0] rdMux;

    reg [2:0] stateQ;
    reg endQ;
    reg [7:0] txQ;
    reg [7:0] rxQ;
    reg [3:0] edgeQ;
    reg [9:0] divQ;
    reg sckQ;
    reg [7:0] tselQ;
    reg sckOutEnQ;
    reg moEnQ;
    reg soEnQ;
    reg irqQ;
    reg txReadyQ;
    reg rxReadyQ;

    wire spiEn = serialControlRegQ[`SMSF_CTRL_EN];
    wire masterMode = serialControlRegQ[`SMSF_CTRL_MSTR];
    wire clockPolarityBit = serialControlRegQ[`SMSF_CTRL_CLOCK_POLARITY_BIT];
    wire clockPhaseBit = serialControlRegQ[`SMSF_CTRL_CLOCK_PHASE_BIT];
    wire [2:0] rate = serialControlRegQ[`SMSF_CTRL_RATE_HI:`SMSF_CTRL_RATE_LO];
    wire irqEn = serialControlRegQ[`SMSF_CTRL_IE];
    wire fifoEn = fifoControlRegQ[`SMSF_FC_EN];
    wire [6:0] trigLevel = fifoControlRegQ[`SMSF_FC_TRIG_HI:`SMSF_FC_TRIG_LO];

    wire acc = psel & penable & readyQ;
    wire wrAcc = acc & pwrite;
    wire rdAcc = acc & ~pwrite;
    wire hitCtrl = (paddr == `SMSF_OFF_CTRL);
    wire hitStat = (paddr == `SMSF_OFF_STAT);
    wire hitData = (paddr == `SMSF_OFF_DATA);
    wire hitSel = (paddr == `SMSF_OFF_SEL);
    wire hitFctl = (paddr == `SMSF_OFF_FCTL);
    wire mapped = hitCtrl | hitStat | hitData | hitSel | hitFctl;

    wire isIdle = stateQ[0];
    wire isWait = stateQ[1];
    wire isRun = stateQ[2];
    wire busy = ~isIdle;
    wire ssLow = ~sync2Q[3];
    wire sckNow = sync2Q[0];
    wire slaveSel = spiEn & ~masterMode & ssLow;
    wire modeFault = spiEn & masterMode & ssLow;
    wire sckEdge = sckNow ^ sckPrevQ;
    wire leadEdge = sckEdge & (sckNow != clockPolarityBit);
    wire [9:0] halfLimit = (`SMSF_HALF_MIN << rate) - 10'h001;
    wire masterTick = (divQ == 10'h000);
    wire slaveEv = isWait ? leadEdge : (isRun & sckEdge);
    wire ev = masterMode ? (isRun & masterTick) : slaveEv;
    wire dataIn = masterMode ? sync2Q[1] : sync2Q[2];
    wire sampleNow = ev & (edgeQ[0] == clockPhaseBit);
    wire shiftNow = ev & (edgeQ[0] != clockPhaseBit) & ~(clockPhaseBit & (edgeQ == 4'h0));
    wire lastEdge = ev & (edgeQ == `SMSF_LAST_EDGE);
    wire [7:0] rxFinal = sampleNow ? {rxQ[6:0], dataIn} : rxQ;
    wire abort = busy & (masterMode ? modeFault : ~slaveSel);
    wire done = lastEdge & ~abort;

    wire [6:0] cap = ~fifoEn ? `SMSF_CAP_ONE :
        (fifoControlRegQ[`SMSF_FC_BIG] ? `SMSF_CAP_BIG : `SMSF_CAP_SMALL);
    wire txWrReady;
    wire txRdValid;
    wire [7:0] txHead;
    wire [6:0] txCount;
    wire rxWrReady;
    wire rxRdValid;
    wire [7:0] rxHead;
    wire [6:0] rxCount;

    // One idle cycle with selects high between back-to-back transfers
    wire masterStart = isIdle & ~endQ & spiEn & masterMode & ~modeFault & ~modfQ & txRdValid;
    wire slaveStart = isIdle & slaveSel;
    wire txPop = masterStart | (slaveStart & txRdValid);
    wire dataWr = wrAcc & hitData;
    // In SPI mode a write while busy or still queued is a collision
    wire collide = dataWr & ~fifoEn & (busy | txRdValid);
    // FIFO mode: a write to a full FIFO is dropped
    wire txPush = dataWr & ~collide;
    wire rxPop = rdAcc & hitData & rxTakeQ;
    wire txClr = wrAcc & hitFctl & pwdata[`SMSF_FC_TXCLR];
    wire rxClr = wrAcc & hitFctl & pwdata[`SMSF_FC_RXCLR];
    wire dataAcc = acc & hitData;
    wire trigHit = fifoEn & (rxCount >= trigLevel) & (rxCount != 7'h00);

    smsf_fifo u_tx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .clr(txClr),
        .limit(cap),
        .wrValid(txPush),
        .wrReady(txWrReady),
        .wrData(pwdata[7:0]),
        .rdValid(txRdValid),
        .rdReady(txPop),
        .rdData(txHead),
        .count(txCount)
    );

    smsf_fifo u_rx_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .clr(rxClr),
        .limit(cap),
        .wrValid(done),
        .wrReady(rxWrReady),
        .wrData(rxFinal),
        .rdValid(rxRdValid),
        .rdReady(rxPop),
        .rdData(rxHead),
        .count(rxCount)
    );

    always @(posedge clk_sys) begin
        if (rst) begin
            sync1Q <= 4'h8;
            sync2Q <= 4'h8;
            sckPrevQ <= 1'b0;
        end else begin
            sync1Q <= {slaveSelectN, si, mi, scki};
            sync2Q <= sync1Q;
            sckPrevQ <= sync2Q[0];
        end
    end

    always @* begin
        rdMux = 32'h00000000;
        case (paddr)
            `SMSF_OFF_CTRL: rdMux = {24'h000000, serialControlRegQ};
            `SMSF_OFF_STAT: rdMux = {24'h000000, busy, ~rxRdValid, ~txWrReady,
                trigHit, ovrQ, modfQ, wcolQ, tcfQ};
            `SMSF_OFF_DATA: rdMux = {24'h000000, rxRdValid ? rxHead : 8'h00};
            `SMSF_OFF_SEL: rdMux = {24'h000000, selectPatternRegQ};
            `SMSF_OFF_FCTL: rdMux = {17'h00000, fifoControlRegQ};
            default: rdMux = 32'h00000000;
        endcase
    end

    // APB slave: one wait state, answer registered
    always @(posedge clk_sys) begin
        if (rst) begin
            readyQ <= 1'b0;
            slverrQ <= 1'b0;
            prdataQ <= 32'h00000000;
            rxTakeQ <= 1'b0;
        end else begin
            readyQ <= psel & penable & ~readyQ;
            if (psel & penable & ~readyQ) begin
                prdataQ <= rdMux;
                slverrQ <= ~mapped;
                rxTakeQ <= rxRdValid;
            end
        end
    end

    // Control, select pattern and FIFO control registers
    always @(posedge clk_sys) begin
        if (rst) begin
            serialControlRegQ <= `SMSF_CTRL_RST;
            fifoControlRegQ <= `SMSF_FCTL_RST;
            selectPatternRegQ <= `SMSF_SEL_RST;
        end else begin
            if (wrAcc & hitCtrl) begin
                serialControlRegQ <= pwdata[7:0];
            end
            if (busy & masterMode & modeFault) begin
                serialControlRegQ[`SMSF_CTRL_MSTR] <= 1'b0;
            end else if (isIdle & modeFault) begin
                serialControlRegQ[`SMSF_CTRL_MSTR] <= 1'b0;
            end
            if (wrAcc & hitSel) begin
                selectPatternRegQ <= pwdata[7:0];
            end
            if (wrAcc & hitFctl) begin
                fifoControlRegQ <= {pwdata[14:3], 2'b00, pwdata[0]};
            end
        end
    end

    // Status flags: set by events, cleared by status read then access
    always @(posedge clk_sys) begin
        if (rst) begin
            tcfQ <= 1'b0;
            wcolQ <= 1'b0;
            modfQ <= 1'b0;
            ovrQ <= 1'b0;
            seenQ <= 4'h0;
        end else begin
            tcfQ <= done | (tcfQ & ~(dataAcc & seenQ[`SMSF_ST_TCF]));
            wcolQ <= collide | (wcolQ & ~(dataAcc & seenQ[`SMSF_ST_WCOL]));
            modfQ <= modeFault | (modfQ & ~(wrAcc & hitCtrl & seenQ[`SMSF_ST_MODF]));
            ovrQ <= (done & ~rxWrReady) | (ovrQ & ~(dataAcc & seenQ[`SMSF_ST_OVR]));
            if (rdAcc & hitStat) begin
                seenQ <= prdataQ[3:0];
            end else if (dataAcc) begin
                seenQ <= {seenQ[`SMSF_ST_OVR], seenQ[`SMSF_ST_MODF], 2'b00};
                if (wrAcc & hitCtrl) begin
                    seenQ[`SMSF_ST_MODF] <= 1'b0;
                end
            end else if (wrAcc & hitCtrl) begin
                seenQ[`SMSF_ST_MODF] <= 1'b0;
            end
        end
    end

    // Shift engine shared by master and slave roles
    always @(posedge clk_sys) begin
        if (rst) begin
            stateQ <= ST_IDLE;
            endQ <= 1'b0;
            txQ <= 8'h00;
            rxQ <= 8'h00;
            edgeQ <= 4'h0;
            divQ <= 10'h000;
            sckQ <= 1'b0;
            tselQ <= `SMSF_SEL_IDLE;
        end else begin
            endQ <= abort | done;
            case (stateQ)
                ST_IDLE: begin
                    sckQ <= clockPolarityBit;
                    edgeQ <= 4'h0;
                    tselQ <= `SMSF_SEL_IDLE;
                    if (masterStart) begin
                        txQ <= txHead;
                        rxQ <= 8'h00;
                        divQ <= halfLimit;
                        tselQ <= selectPatternRegQ;
                        stateQ <= ST_RUN;
                    end else if (slaveStart) begin
                        txQ <= txRdValid ? txHead : 8'h00;
                        rxQ <= 8'h00;
                        stateQ <= ST_WAIT;
                    end
                end
                ST_WAIT, ST_RUN: begin
                    if (masterMode & isRun) begin
                        if (masterTick) begin
                            divQ <= halfLimit;
                            sckQ <= ~sckQ;
                        end else begin
                            divQ <= divQ - 10'h001;
                        end
                    end
                    // Slave counts only from the first leading edge
                    if (isWait & leadEdge) begin
                        stateQ <= ST_RUN;
                    end
                    if (ev) begin
                        edgeQ <= edgeQ + 4'h1;
                    end
                    if (sampleNow) begin
                        rxQ <= {rxQ[6:0], dataIn};
                    end
                    if (shiftNow) begin
                        txQ <= {txQ[6:0], 1'b0};
                    end
                    if (abort | done) begin
                        stateQ <= ST_IDLE;
                    end
                end
                default: begin
                    stateQ <= ST_IDLE;
                end
            endcase
        end
    end

    // Registered pin enables, interrupt and ready outputs
    always @(posedge clk_sys) begin
        if (rst) begin
            sckOutEnQ <= 1'b0;
            moEnQ <= 1'b0;
            soEnQ <= 1'b0;
            irqQ <= 1'b0;
            txReadyQ <= 1'b0;
            rxReadyQ <= 1'b0;
        end else begin
            sckOutEnQ <= spiEn & masterMode & ~modeFault & ~modfQ;
            moEnQ <= spiEn & masterMode & ~modeFault & ~modfQ;
            soEnQ <= slaveSel & ~modfQ;
            irqQ <= irqEn & (tcfQ | wcolQ | modfQ | ovrQ | trigHit);
            txReadyQ <= txWrReady & ~(~fifoEn & busy);
            rxReadyQ <= rxRdValid;
        end
    end

    assign prdata = prdataQ;
    assign pready = readyQ;
    assign pslverr = slverrQ;
    assign sckOut = sckQ;
    assign sckOutEn = sckOutEnQ;
    assign masterDataOut = txQ[7];
    assign masterDataOutEn = moEnQ;
    assign slaveDataOut = txQ[7];
    assign slaveDataOutEn = soEnQ;
    assign targetSelectOutputs = tselQ;
    assign irq = irqQ;
    assign txReady = txReadyQ;
    assign rxReady = rxReadyQ;
endmodule
